// *** rtl/crs_cfg.svh ***
// crs_cfg.svh: timing counts and reset values for the clock and reset select block
// assumes clk_sys at 40 MHz stands in for the oscillator input
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
`define CRS_RST_PERIODS 64
`define CRS_SOF_STATES 8
`define CRS_DIV_FULL 4
`define CRS_DIV_HALF 2
`define CRS_LC_RESET 1'b1
`endif

// *** rtl/crs_pkg.sv ***
// crs_pkg.sv: types shared by the clock and reset select block
// assumes nothing beyond crs_cfg.svh
package crs_pkg;
	typedef enum logic {CRS_LS, CRS_FS} crs_speed_e;
	typedef logic [1:0] crs_div_t;
endpackage

// *** rtl/crs_clock_reset_select.sv ***
// crs_clock_reset_select.sv: core clock rate select, reset qualify, strap
// latch and start-of-frame strobe
// assumes pin inputs arrive asynchronous to clk_sys; clk_sys is the
// oscillator input; core clock is given as a one-cycle enable pulse
`include "crs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - both selects low: 6MHz, LS, 3MHz core
// - pll high, fs low, lc clear: 6MHz
// - pll high, fs low, lc set: 3MHz
// - both high, lc clear: PLL, FS, 6MHz
// - both high, lc set: PLL, FS, 3MHz
// - reset sets the low-clock bit
// - low-clock bit writable at any time outside reset
// - USB 1.5 or 12 Mbps, 4x sampling
// - reset after 64 oscillator periods high
// - port reset immediately while reset pin high
// - reset pin exits idle and power-down
// - latch external-fetch strap at reset
// - continuous SE0 holds device in reset
// - 8-state active-low SOF strobe when locked
module crs_clock_reset_select
	import crs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// pins
	input wire logic reset_pin,
	input wire logic pll_select_pin,
	input wire logic full_speed_select_pin,
	input wire logic external_fetch_strap,
	input wire logic usb_se0,
	// firmware control
	input wire logic low_clock_wr,
	input wire logic low_clock_wdata,
	input wire logic low_power_mode,
	// frame timer
	input wire logic frame_locked,
	input wire logic sof_event,
	// outputs
	output logic low_clock_bit,
	output logic core_clk_en,
	output logic pll_enable,
	output crs_pkg::crs_speed_e usb_speed,
	output logic usb_sample_en,
	output logic osc_is_12mhz,
	output logic port_reset,
	output logic core_reset,
	output logic wake_normal,
	output logic internal_fetch_en,
	output logic sof_strobe_n
);
	import crs_pkg::*;

	logic rpin_m_q, rpin_q, pll_m_q, pll_q, fs_m_q, fs_q;
	logic ea_m_q, ea_q, se0_m_q, se0_q;
	logic [6:0] rcnt_q;
	logic core_rst_d;
	logic lc_q;
	logic [1:0] cdiv_q;
	logic ldiv_q;
	logic [3:0] sof_cnt_q;
	crs_div_t div_sel;

	// two-stage synchronisers on every pin
	always_ff @(posedge clk_sys)
	begin
		rpin_m_q <= reset_pin;
		rpin_q <= rpin_m_q;
		pll_m_q <= pll_select_pin;
		pll_q <= pll_m_q;
		fs_m_q <= full_speed_select_pin;
		fs_q <= fs_m_q;
		ea_m_q <= external_fetch_strap;
		ea_q <= ea_m_q;
		se0_m_q <= usb_se0;
		se0_q <= se0_m_q;
	end

	// port reset follows the pin with no oscillator-qualified count
	always_ff @(posedge clk_sys)
		port_reset <= rst | rpin_q;

	// qualify reset pin over 64 periods; SE0 also holds reset
	always_ff @(posedge clk_sys)
	begin
		if (rst || !rpin_q)
			rcnt_q <= '0;
		else if (rcnt_q != 7'(`CRS_RST_PERIODS))
			rcnt_q <= rcnt_q + 7'h01;
	end
	assign core_rst_d = rst || (rcnt_q == 7'(`CRS_RST_PERIODS)) || se0_q;
	always_ff @(posedge clk_sys)
	begin
		core_reset <= core_rst_d;
		wake_normal <= core_rst_d & low_power_mode;
	end

	// strap caught at reset, held while running
	always_ff @(posedge clk_sys)
		if (core_rst_d)
			internal_fetch_en <= ea_q;

	// low-clock bit: set by reset, written by firmware any time reset is not active
	always_ff @(posedge clk_sys)
	begin
		if (core_rst_d)
			lc_q <= `CRS_LC_RESET;
		else if (low_clock_wr)
			lc_q <= low_clock_wdata;
	end
	assign low_clock_bit = lc_q;

	// 6 MHz oscillator or lc set gives the slower divider; value is the
	// reload count of the divider, one less than its period
	always_comb
	begin
		if (!pll_q || lc_q)
			div_sel = crs_div_t'(`CRS_DIV_FULL - 1);
		else
			div_sel = crs_div_t'(`CRS_DIV_HALF - 1);
	end

	// rate only changes at a pulse boundary, so no short pulse appears
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cdiv_q <= '0;
			core_clk_en <= 1'b0;
		end
		else if (cdiv_q == 2'h0)
		begin
			cdiv_q <= div_sel;
			core_clk_en <= 1'b1;
		end
		else
		begin
			cdiv_q <= cdiv_q - 2'h1;
			core_clk_en <= 1'b0;
		end
	end

	// rate selection and USB sampling enable
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pll_enable <= 1'b0;
			usb_speed <= CRS_LS;
			osc_is_12mhz <= 1'b0;
			usb_sample_en <= 1'b0;
			ldiv_q <= 1'b0;
		end
		else
		begin
			pll_enable <= pll_q & fs_q;
			usb_speed <= (pll_q & fs_q) ? CRS_FS : CRS_LS;
			osc_is_12mhz <= pll_q;
			ldiv_q <= ~ldiv_q;
			// stand-in: full speed samples every cycle, low speed every other
			usb_sample_en <= (pll_q & fs_q) | ldiv_q;
		end
	end

	// SOF strobe: 8 states, started only while the frame timer is locked
	always_ff @(posedge clk_sys)
	begin
		if (core_rst_d)
		begin
			sof_cnt_q <= '0;
			sof_strobe_n <= 1'b1;
		end
		else if (sof_event && frame_locked)
		begin
			sof_cnt_q <= 4'(`CRS_SOF_STATES);
			sof_strobe_n <= 1'b0;
		end
		else if (sof_cnt_q != 4'h0)
		begin
			if (core_clk_en)
				sof_cnt_q <= sof_cnt_q - 4'h1;
			// stays low until the last state time is used up
			sof_strobe_n <= (sof_cnt_q == 4'h1) && core_clk_en;
		end
		else
			sof_strobe_n <= 1'b1;
	end

	chk_lc_reset_set: assert property (@(posedge clk_sys)
		$past(core_rst_d) |-> low_clock_bit)
		else $error("low clock bit not set by reset");
	chk_pll_both_pins: assert property (@(posedge clk_sys)
		disable iff (rst) pll_q & fs_q |=> pll_enable)
		else $error("pll not enabled");

	// pin rises, then stays high for eight samples
	sequence crs_pin_rise_held;
		!rpin_q ##1 rpin_q [*8];
	endsequence
	chk_reset_count: assert property (@(posedge clk_sys)
		disable iff (rst)
		crs_pin_rise_held |-> !core_reset || se0_q || $past(se0_q))
		else $error("reset qualified too early");
	chk_sof_locked: assert property (@(posedge clk_sys)
		disable iff (core_rst_d)
		sof_event && frame_locked |=> !sof_strobe_n)
		else $error("sof strobe missing");
	chk_sof_hold: assert property (@(posedge clk_sys)
		disable iff (rst)
		!core_rst_d && sof_cnt_q != 4'h0
		&& !(sof_cnt_q == 4'h1 && core_clk_en) |=> !sof_strobe_n)
		else $error("sof strobe cut short");
	chk_sof_unlocked: assert property (@(posedge clk_sys)
		disable iff (rst)
		sof_strobe_n && sof_cnt_q == 4'h0 && !(sof_event && frame_locked)
		|=> sof_strobe_n)
		else $error("sof strobe without lock");
	chk_lc_write: assert property (@(posedge clk_sys)
		disable iff (rst)
		!core_rst_d && low_clock_wr |=> lc_q == $past(low_clock_wdata))
		else $error("low clock write lost");
	chk_port_reset: assert property (@(posedge clk_sys)
		rpin_q |=> port_reset)
		else $error("port reset late");
	chk_se0_hold: assert property (@(posedge clk_sys)
		se0_q |=> core_reset)
		else $error("se0 did not hold reset");
endmodule // crs_clock_reset_select
`default_nettype wire

// *** bench/crs_board.sv ***
// crs_board.sv: board model of strap pins and reset pin
// assumes the bench picks straps and asks for a reset pulse
`timescale 1ns/100ps
`default_nettype none
module crs_board(
	// control from bench
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [1:0] sel,
	// pins
	output logic reset_pin,
	output logic pll_select_pin,
	output logic full_speed_select_pin
);
	int n = 0;
	assign pll_select_pin = sel[1];
	assign full_speed_select_pin = sel[0];
	// pulse is kept well past 64 periods so a slack sync still qualifies
	always @(posedge clk_sys)
		if (go)
			n <= 80;
		else if (n > 0)
			n <= n - 1;
	assign reset_pin = (n > 0);
endmodule // crs_board
`default_nettype wire

// *** bench/testbench.sv ***
// testbench.sv: self-checking bench for the clock and reset select block
// assumes crs_board drives the pll and speed select straps and the reset pin; the bench drives the external-fetch strap
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import crs_pkg::*;
	logic clk_sys = 0, rst = 1, go = 0, fx = 1, se0 = 0, wr = 0, wd = 0;
	logic lock = 0, sof = 0, lp = 0;
	logic [1:0] sel = 0;
	logic lc, ce, pll, pr, cr, ife, sn, smp, o12, wk;
	crs_speed_e spd;
	wire logic rp, ps, fs;
	int miscompares = 0, tests_run = 0, cyc = 0;
	always #12.5 clk_sys = ~clk_sys;
	crs_board brd_u(.clk_sys, .go, .sel, .reset_pin(rp),
		.pll_select_pin(ps), .full_speed_select_pin(fs));
	crs_clock_reset_select dut_u(.clk_sys, .rst, .reset_pin(rp),
		.pll_select_pin(ps), .full_speed_select_pin(fs),
		.external_fetch_strap(fx), .usb_se0(se0), .low_clock_wr(wr),
		.low_clock_wdata(wd), .low_power_mode(lp), .frame_locked(lock),
		.sof_event(sof), .low_clock_bit(lc), .core_clk_en(ce),
		.pll_enable(pll), .usb_speed(spd), .usb_sample_en(smp),
		.osc_is_12mhz(o12), .port_reset(pr), .core_reset(cr),
		.wake_normal(wk), .internal_fetch_en(ife), .sof_strobe_n(sn));
	task automatic results;
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			results;
		end
	end
	task automatic chk(string n, logic [3:0] e, logic [3:0] g);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// spacing in cycles between two core clock enables
	task automatic per(output int n);
		n = 1;
		while (ce !== 1'b1)
			step(1);
		step(1);
		while (ce !== 1'b1)
		begin
			step(1);
			n++;
		end
	endtask
	task automatic t_rate(logic [1:0] s, logic l, logic [3:0] d);
		int n;
		int k;
		sel = s;
		wr = 1;
		wd = l;
		step(1);
		wr = 0;
		step(4);
		per(n);
		per(n);
		chk("period", d, n[3:0]);
		chk("pll", s == 2'h3, pll);
		chk("speed", s[0], spd);
		k = 0;
		repeat (4)
		begin
			k += smp;
			step(1);
		end
		chk("sample", (s == 2'h3) ? 4'h4 : 4'h2, k[3:0]);
		chk("osc_12mhz", s[1], o12);
		chk("low_clock", l, lc);
	endtask
	task automatic t_sof;
		lock = 0;
		sof = 1;
		step(1);
		sof = 0;
		step(2);
		chk("sof_n", 1, sn);
		lock = 1;
		sof = 1;
		step(1);
		sof = 0;
		step(20);
		chk("sof_n", 0, sn);
		step(20);
		chk("sof_n", 1, sn);
	endtask
	task automatic t_pin;
		wr = 1;
		wd = 0;
		step(1);
		wr = 0;
		chk("low_clock", 0, lc);
		fx = 0;
		go = 1;
		step(1);
		go = 0;
		step(4);
		chk("port_reset", 1, pr);
		step(71);
		chk("core_reset", 1, cr);
		chk("fetch", 0, ife);
		step(12);
		chk("core_reset", 0, cr);
		chk("low_clock", 1, lc);
		se0 = 1;
		lp = 1;
		fx = 1;
		step(5);
		chk("core_reset", 1, cr);
		chk("wake", 1, wk);
		se0 = 0;
		lp = 0;
		fx = 0;
		step(5);
		chk("core_reset", 0, cr);
		chk("wake", 0, wk);
		chk("fetch", 1, ife);
	endtask
	initial
	begin
		step(10);
		rst = 0;
		step(2);
		chk("low_clock", 1, lc);
		t_rate(2'h0, 0, 4);
		t_rate(2'h0, 1, 4);
		t_rate(2'h2, 0, 2);
		t_rate(2'h2, 1, 4);
		t_rate(2'h3, 0, 2);
		t_rate(2'h3, 1, 4);
		t_sof;
		t_pin;
		results;
	end
endmodule // testbench
`default_nettype wire
